// file: inc/ipcs_pkg.sv
// Constants for the I/O pin power and configuration sequencer.
// Assumes one core clock; all strap and supply inputs arrive asynchronously.
package ipcs_pkg;

   // ---------------------------------------------------------------
   // Idle pin termination encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] TERM_WEAK_LOW  = 2'h0;
   localparam logic [1:0] TERM_WEAK_HIGH = 2'h1;
   localparam logic [1:0] TERM_NONE      = 2'h2;
   localparam logic [1:0] TERM_DEFAULT   = TERM_WEAK_LOW;

   // ---------------------------------------------------------------
   // Register map (plain port, word index)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CONTROL  = 4'h0;   // b0 init done, b1 config done, b3:2 term
   localparam logic [3:0] REG_STATUS   = 4'h1;   // phase, mode, flags
   localparam logic [3:0] REG_USERPULL = 4'h2;   // low bits pull-up en, bits from 16 pull-down en, one per pin
   localparam logic [3:0] REG_SRINV    = 4'h3;   // per-register inversion of set/reset
   localparam int CTL_INIT_DONE_BIT = 0;
   localparam int CTL_CFG_DONE_BIT  = 1;
   localparam int CTL_TERM_LSB      = 2;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 8000;
   localparam int WE_DELAY_CYCLES    = 1;      // write enable after tristate release
   localparam int SUPPLY_STABLE_NS   = 64;     // supplies must read valid this long
   localparam int SUPPLY_STABLE_CYC  =
      ((SUPPLY_STABLE_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ---------------------------------------------------------------
   // Sequencer phases
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      IPCS_POR,
      IPCS_CLEAR,
      IPCS_CONFIG,
      IPCS_STARTUP,
      IPCS_WE_WAIT,
      IPCS_USER
   } ipcs_phase_t;

endpackage

// file: hdl/ipcs_sync.sv
// Two-stage synchroniser bank for asynchronous pins.
// Assumes the first stage feeds only the second stage.
`timescale 1ns/1ps
module ipcs_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output      logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   // Both stages hold while the clock enable is low
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1 <= '0;
         sync_o <= '0;
      end
      else if (ce_i)
      begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule

// file: hdl/ipcs_sequencer.sv
// Power-on, configuration and user-mode sequencer for I/O pins and global nets.
// Assumes supplies, straps and the configuration engine are asynchronous inputs.
//
// Contract
// - Configuration waits until core, auxiliary and bank 2 supplies are all valid.
// - Every output driver stays high-impedance before configuration begins.
// - Strap low enables config pull-ups until configuration ends; high lets pins float.
// - An unconnected config pull-up strap reads as high.
// - At power-up memory clearing starts and global set/reset forces I/O registers low.
// - Init-complete goes high after clearing; mode bits are sampled on that edge (here one cycle earlier, as clearing ends).
// - Drivers stay high-impedance throughout configuration; pull-ups follow the strap.
// - Configuration end releases set/reset; registers low unless their polarity is inverted.
// - Start-up releases global tristate, enabling used pins; unused pins default pulled down.
// - Unused pins terminate weak high, weak low or none; weak low is default.
// - Write enable releases one cycle after tristate release by default.
// - User mode applies user pull settings; strap pin becomes ordinary I/O.
// - Boundary-scan EXTEST or HIGHZ keeps the pull-down active.
// - Input-only and unused dual-purpose pins follow the same behaviour; here pins flagged pin_is_cfg_i get no strap pull-up before user mode.
`timescale 1ns/1ps
module ipcs_sequencer
   import ipcs_pkg::*;
#(
   parameter int NPINS = 8
)
(
   // Clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   // Supply monitors and straps (asynchronous)
   input  wire logic                   vcc_core_ok_i,
   input  wire logic                   vcc_aux_ok_i,
   input  wire logic                   vcc_bank2_ok_i,
   input  wire logic                   config_pullup_disable_i,
   input  wire logic                   config_pullup_disable_oe_n_i,
   input  wire logic [2:0]             mode_select_i,
   // Configuration engine events (asynchronous)
   input  wire logic                   mem_clear_done_i,
   input  wire logic                   config_done_i,
   // Boundary-scan state
   input  wire logic                   scan_extest_i,
   input  wire logic                   scan_highz_i,
   // Pin usage from the loaded design
   input  wire logic [NPINS-1:0]       pin_used_i,
   input  wire logic [NPINS-1:0]       pin_is_cfg_i,
   // Register port
   input  wire logic [3:0]             reg_addr_i,
   input  wire logic [31:0]            reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output      logic [31:0]            reg_rdata_o,
   // Global nets and pin controls
   output      logic                   global_set_reset_o,
   output      logic                   global_output_tristate_o,
   output      logic                   global_write_enable_o,
   output      logic                   initialization_complete_n_o,
   output      logic                   mem_clear_o,
   output      logic [2:0]             config_mode_o,
   output      logic [NPINS-1:0]       pin_oe_n_o,
   output      logic [NPINS-1:0]       pin_pullup_o,
   output      logic [NPINS-1:0]       pin_pulldown_o,
   output      logic [NPINS-1:0]       reg_init_value_o,
   output      logic                   strap_is_gpio_o
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (NPINS < 1 || NPINS > 16)
   begin : g_bad_npins
      $error("NPINS must lie between 1 and 16");
   end

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn_in;
   logic             s_core;
   logic             s_aux;
   logic             s_bank2;
   logic             s_strap;
   logic [2:0]       s_mode;
   logic             s_clr_done;
   logic             s_cfg_done;
   logic             s_strap_float;

   // A floating strap is reported by its pad as not driven; the internal pull-up wins
   assign s_strap_float = config_pullup_disable_oe_n_i;
   assign raw_in = {s_strap_float, config_done_i, mem_clear_done_i, mode_select_i,
                    config_pullup_disable_i, vcc_bank2_ok_i, vcc_aux_ok_i, vcc_core_ok_i};

   ipcs_sync #(.WIDTH(NSYNC)) u_sync
   (
      .clk_i   (core_clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i (raw_in),
      .sync_o  (syn_in)
   );

   assign s_core     = syn_in[0];
   assign s_aux      = syn_in[1];
   assign s_bank2    = syn_in[2];
   assign s_strap    = syn_in[3] | syn_in[9];
   assign s_mode     = syn_in[6:4];
   assign s_clr_done = syn_in[7];
   assign s_cfg_done = syn_in[8];

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   logic [31:0]      control;
   logic [NPINS-1:0] user_pullup;
   logic [NPINS-1:0] user_pulldown;
   logic [NPINS-1:0] sr_invert;
   logic             sw_init_done;
   logic             sw_cfg_done;
   logic [1:0]       term_sel;
   logic             wr_control;
   logic             wr_userpull;
   logic             wr_srinv;

   assign wr_control  = reg_wr_i && (reg_addr_i == REG_CONTROL);
   assign wr_userpull = reg_wr_i && (reg_addr_i == REG_USERPULL);
   assign wr_srinv    = reg_wr_i && (reg_addr_i == REG_SRINV);
   assign sw_init_done = control[CTL_INIT_DONE_BIT];
   assign sw_cfg_done  = control[CTL_CFG_DONE_BIT];
   assign term_sel     = control[CTL_TERM_LSB +: 2];

   // Register writes; termination code 3 is illegal and falls back to the default
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         control       <= CONTROL_RESET;
         user_pullup   <= '0;
         user_pulldown <= '0;
         sr_invert     <= '0;
      end
      else if (ce_i)
      begin
         if (wr_control)
            control <= reg_wdata_i;
         if (wr_userpull)
         begin
            user_pullup   <= reg_wdata_i[NPINS-1:0];
            user_pulldown <= reg_wdata_i[16 +: NPINS];
         end
         if (wr_srinv)
            sr_invert <= reg_wdata_i[NPINS-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Phase sequencer
   // ---------------------------------------------------------------
   ipcs_phase_t phase;
   ipcs_phase_t next_phase;
   logic [7:0]  stable_cnt;
   logic [7:0]  next_stable_cnt;
   logic        supplies_ok;
   logic        stable_reached;
   logic        clear_done;
   logic        cfg_done;

   assign supplies_ok    = s_core & s_aux & s_bank2;
   assign stable_reached = (stable_cnt == 8'(SUPPLY_STABLE_CYC));
   assign clear_done     = s_clr_done | sw_init_done;
   assign cfg_done       = s_cfg_done | sw_cfg_done;
   assign next_stable_cnt = (phase == IPCS_POR && supplies_ok && !stable_reached)
                            ? stable_cnt + 8'h01 : 8'h00;

   // Any supply dropping sends the sequence back to power-on
   always_comb
   begin
      next_phase = phase;
      if (!supplies_ok)
         next_phase = IPCS_POR;
      else
      begin
         unique case (phase)
            IPCS_POR:     if (stable_reached) next_phase = IPCS_CLEAR;
            IPCS_CLEAR:   if (clear_done)     next_phase = IPCS_CONFIG;
            IPCS_CONFIG:  if (cfg_done)       next_phase = IPCS_STARTUP;
            IPCS_STARTUP: next_phase = IPCS_WE_WAIT;
            IPCS_WE_WAIT: next_phase = IPCS_USER;
            IPCS_USER:    next_phase = IPCS_USER;
            default:      next_phase = IPCS_POR;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase      <= IPCS_POR;
         stable_cnt <= 8'h00;
      end
      else if (ce_i)
      begin
         phase      <= next_phase;
         stable_cnt <= next_stable_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Global net and pin decode
   // ---------------------------------------------------------------
   logic             next_gsr;
   logic             next_gts;
   logic             next_gwe;
   logic             next_init_n;
   logic             next_clear;
   logic             in_user;
   logic             pre_user;
   logic             scan_pd;
   logic             mode_sample;
   logic [1:0]       term_eff;
   logic [NPINS-1:0] affected;
   logic [NPINS-1:0] next_oe_n;
   logic [NPINS-1:0] next_pu;
   logic [NPINS-1:0] next_pd;
   logic [NPINS-1:0] next_init_val;

   assign in_user  = (phase == IPCS_WE_WAIT) || (phase == IPCS_USER);
   assign pre_user = !in_user && (phase != IPCS_STARTUP);
   assign scan_pd  = scan_extest_i | scan_highz_i;
   assign term_eff = (term_sel == 2'h3) ? TERM_DEFAULT : term_sel;
   // Configuration pins keep their config role until user mode; all others follow the sequence
   assign affected = ~pin_is_cfg_i | {NPINS{in_user}};

   assign next_gsr    = (phase == IPCS_POR) || (phase == IPCS_CLEAR)
                        || (phase == IPCS_CONFIG);
   assign next_gts    = !in_user;
   assign next_gwe    = (phase == IPCS_USER);
   assign next_init_n = (phase == IPCS_CONFIG) || (phase == IPCS_STARTUP)
                        || in_user;
   assign next_clear  = (phase == IPCS_CLEAR);
   assign mode_sample = (phase == IPCS_CLEAR) && (next_phase == IPCS_CONFIG);

   // Output enables low only for used pins once tristate is released
   assign next_oe_n = ~(pin_used_i & affected & {NPINS{in_user}});

   // Strap-driven pull-ups before start-up, none during start-up, user or idle termination after
   assign next_pu = pre_user
                    ? (affected & {NPINS{!s_strap}})
                    : (in_user
                       ? ((pin_used_i & user_pullup)
                          | (~pin_used_i & {NPINS{term_eff == TERM_WEAK_HIGH}}))
                       : '0);
   assign next_pd = {NPINS{scan_pd}}
                    | (in_user
                       ? ((pin_used_i & user_pulldown)
                          | (~pin_used_i & {NPINS{term_eff == TERM_WEAK_LOW}}))
                       : '0);

   // Set/reset forces low; inverted polarity gives a high reset value
   assign next_init_val = next_gsr ? '0 : sr_invert;

   // Output registers: all outputs come straight from flip-flops
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         global_set_reset_o          <= 1'b1;
         global_output_tristate_o    <= 1'b1;
         global_write_enable_o       <= 1'b0;
         initialization_complete_n_o <= 1'b0;
         mem_clear_o                 <= 1'b0;
         pin_oe_n_o                  <= '1;
         pin_pullup_o                <= '0;
         pin_pulldown_o              <= '0;
         reg_init_value_o            <= '0;
         strap_is_gpio_o             <= 1'b0;
      end
      else if (ce_i)
      begin
         global_set_reset_o          <= next_gsr;
         global_output_tristate_o    <= next_gts;
         global_write_enable_o       <= next_gwe;
         initialization_complete_n_o <= next_init_n;
         mem_clear_o                 <= next_clear;
         pin_oe_n_o                  <= next_oe_n;
         pin_pullup_o                <= next_pu;
         pin_pulldown_o              <= next_pd;
         reg_init_value_o            <= next_init_val;
         strap_is_gpio_o             <= in_user;
      end
   end

   // Mode is caught only as clearing hands over to configuration, one cycle before init-complete rises, and held afterward
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         config_mode_o <= 3'h0;
      else if (ce_i && mode_sample)
         config_mode_o <= s_mode;
   end

   // ---------------------------------------------------------------
   // Read port: data one cycle after the strobe, zero elsewhere
   // ---------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   assign status_word = {16'h0000, 4'h0, strap_is_gpio_o, s_strap, supplies_ok,
                         global_write_enable_o, global_output_tristate_o,
                         global_set_reset_o, config_mode_o, phase};
   assign rd_mux = (reg_addr_i == REG_CONTROL)  ? control :
                   (reg_addr_i == REG_STATUS)   ? status_word :
                   (reg_addr_i == REG_USERPULL) ? (32'(user_pulldown) << 16) | 32'(user_pullup) :
                   (reg_addr_i == REG_SRINV)    ? 32'(sr_invert) : 32'h0000_0000;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (ce_i)
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
   end

endmodule

// file: testbench/ipcs_cfg_src.sv
// Configuration source model: answers memory clearing and loading.
// Assumes the bench's reset and a slow_i level that picks long or short delays.
`timescale 1ns/1ps
module ipcs_cfg_src
(
   // Clock and control
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   // Sequencer side
   input  wire logic mem_clear_i,
   input  wire logic init_n_i,
   output      logic clear_done_o,
   output      logic cfg_done_o
);
   logic [7:0] cnt;
   wire  [7:0] dly = slow_i ? 8'h28 : 8'h03;  // Slow source tests patience of the sequencer

   // Done levels rise after a delay and drop only when the sequencer is back at rest
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt          <= 8'h00;
         clear_done_o <= 1'b0;
         cfg_done_o   <= 1'b0;
      end
      else if (!mem_clear_i && !init_n_i)
      begin
         cnt          <= 8'h00;
         clear_done_o <= 1'b0;
         cfg_done_o   <= 1'b0;
      end
      else if ((mem_clear_i && !clear_done_o) || (init_n_i && !cfg_done_o))
      begin
         cnt <= (cnt == dly) ? 8'h00 : cnt + 8'h01;
         if (cnt == dly && mem_clear_i)
            clear_done_o <= 1'b1;
         else if (cnt == dly)
            cfg_done_o <= 1'b1;
      end
   end
endmodule

// file: testbench/ipcs_sequencer_chk.sv
// Port assertions for the sequencer.
// Assumes ce_i stays high while a release step is in flight.
`timescale 1ns/1ps
module ipcs_sequencer_chk
#(
   parameter int NPINS = 8
)
(
   // Inputs watched
   input wire logic             core_clk_i,
   input wire logic             rst_i,
   input wire logic             ce_i,
   input wire logic             vcc_core_ok_i,
   input wire logic             vcc_aux_ok_i,
   input wire logic             vcc_bank2_ok_i,
   input wire logic             config_pullup_disable_i,
   input wire logic             config_pullup_disable_oe_n_i,
   input wire logic             scan_extest_i,
   input wire logic             scan_highz_i,
   input wire logic [NPINS-1:0] pin_is_cfg_i,
   // Outputs watched
   input wire logic             global_set_reset_o,
   input wire logic             global_output_tristate_o,
   input wire logic             global_write_enable_o,
   input wire logic             initialization_complete_n_o,
   input wire logic             mem_clear_o,
   input wire logic [2:0]       config_mode_o,
   input wire logic [NPINS-1:0] pin_oe_n_o,
   input wire logic [NPINS-1:0] pin_pullup_o,
   input wire logic [NPINS-1:0] pin_pulldown_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // A floating strap pad reads high
   wire strap_hi = config_pullup_disable_i | config_pullup_disable_oe_n_i;
   wire any_low  = !(vcc_core_ok_i && vcc_aux_ok_i && vcc_bank2_ok_i);
   wire [NPINS-1:0] ncfg = ~pin_is_cfg_i;

   // Release is three steps: set/reset, then tristate, then write enable
   sequence s_gsr_drop;
      $fell(global_set_reset_o) && ce_i;
   endsequence
   sequence s_release;
      global_output_tristate_o ##1 !global_output_tristate_o ##1 global_write_enable_o;
   endsequence

   chk_tristate_early: assert property (!initialization_complete_n_o |->
      global_output_tristate_o && (&pin_oe_n_o)) else $error("driver active before config");
   chk_cfg_hiz_pins: assert property (global_output_tristate_o |->
      &(pin_oe_n_o | pin_is_cfg_i)) else $error("driver active while tristated");
   chk_pullup_strap: assert property (initialization_complete_n_o && global_set_reset_o |->
      (pin_pullup_o & ncfg) == ({NPINS{!strap_hi}} & ncfg)) else $error("config pull-up wrong");
   chk_clear_gsr: assert property (mem_clear_o |-> global_set_reset_o)
      else $error("clearing without set/reset");
   chk_release_order: assert property (s_gsr_drop |-> s_release)
      else $error("release order wrong");
   chk_we_after_gts: assert property (global_write_enable_o |->
      !global_output_tristate_o && !$past(global_output_tristate_o)) else $error("early write enable");
   chk_scan_pulldown: assert property ((scan_extest_i || scan_highz_i) |=> &pin_pulldown_o)
      else $error("scan pull-down missing");
   chk_por_restart: assert property ((any_low && ce_i) [*5] |->
      global_set_reset_o && global_output_tristate_o && !global_write_enable_o)
      else $error("no return to power-on state");
   chk_mode_hold: assert property (initialization_complete_n_o && $past(initialization_complete_n_o)
      |-> $stable(config_mode_o)) else $error("mode resampled");
   // A low clock enable must freeze the global nets
   chk_ce_freeze: assert property (!ce_i |=> $stable(global_set_reset_o)
      && $stable(global_output_tristate_o) && $stable(global_write_enable_o))
      else $error("global net moved with clock enable low");
endmodule

bind ipcs_sequencer ipcs_sequencer_chk #(.NPINS(NPINS)) u_chk (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .ce_i(ce_i), .vcc_core_ok_i(vcc_core_ok_i), .vcc_aux_ok_i(vcc_aux_ok_i),
   .vcc_bank2_ok_i(vcc_bank2_ok_i), .config_pullup_disable_i(config_pullup_disable_i),
   .config_pullup_disable_oe_n_i(config_pullup_disable_oe_n_i), .scan_extest_i(scan_extest_i),
   .scan_highz_i(scan_highz_i), .pin_is_cfg_i(pin_is_cfg_i),
   .global_set_reset_o(global_set_reset_o), .global_output_tristate_o(global_output_tristate_o),
   .global_write_enable_o(global_write_enable_o), .mem_clear_o(mem_clear_o),
   .initialization_complete_n_o(initialization_complete_n_o), .config_mode_o(config_mode_o),
   .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o), .pin_pulldown_o(pin_pulldown_o));

// file: testbench/io_pin_power_config_sequencer_tb.sv
// Self-checking bench for the sequencer, with a configuration source model.
// Assumes the design's package and modules are compiled first.
`timescale 1ns/1ps
module io_pin_power_config_sequencer_tb;
   import ipcs_pkg::*;
   localparam int NP = 8;
   logic          core_clk_i, rst_i, ce, slow, strap, strap_oe_n, extest, highz, wr, rd;
   logic          clr_done, cfg_done, global_set_reset, global_output_tristate, global_write_enable, init_n, mclr, gpio;
   logic [2:0]    sup, mode, cmode;
   logic [1:0]    term;
   logic [3:0]    addr;
   logic [31:0]   wdata, rdata, got, upull, sinv;
   logic [NP-1:0] used, cfgp, oe_n, pup, pdn, rinit;
   int            miscompares, n_checks, seed;

   ipcs_cfg_src u_ipcs_cfg_src (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
      .mem_clear_i(mclr), .init_n_i(init_n), .clear_done_o(clr_done), .cfg_done_o(cfg_done));
   ipcs_sequencer #(.NPINS(NP)) u_ipcs_sequencer (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .ce_i(ce), .vcc_core_ok_i(sup[0]), .vcc_aux_ok_i(sup[1]), .vcc_bank2_ok_i(sup[2]),
      .config_pullup_disable_i(strap), .config_pullup_disable_oe_n_i(strap_oe_n),
      .mode_select_i(mode), .mem_clear_done_i(clr_done), .config_done_i(cfg_done),
      .scan_extest_i(extest), .scan_highz_i(highz), .pin_used_i(used), .pin_is_cfg_i(cfgp),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .global_set_reset_o(global_set_reset), .global_output_tristate_o(global_output_tristate), .global_write_enable_o(global_write_enable),
      .initialization_complete_n_o(init_n), .mem_clear_o(mclr), .config_mode_o(cmode),
      .pin_oe_n_o(oe_n), .pin_pullup_o(pup), .pin_pulldown_o(pdn), .reg_init_value_o(rinit),
      .strap_is_gpio_o(gpio));

   // 125 MHz core clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bus tasks are entered just after a rising edge
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
      // Idle edge so a following call never re-raises the strobe in this step
      @(posedge core_clk_i);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge core_clk_i);
   endtask
   // Unused pins take the termination; code 3 falls back to weak low
   function automatic logic [NP-1:0] exp_pull(input logic dn);
      logic on;
      on = dn ? (term == TERM_WEAK_LOW || term == 2'h3) : (term == TERM_WEAK_HIGH);
      return (used & (dn ? upull[16 +: NP] : upull[NP-1:0])) | (~used & {NP{on}});
   endfunction

   // Watchdog sized well above six slow sequences
   initial
   begin
      #160000;
      miscompares++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst_i, ce, slow, strap, strap_oe_n, extest, highz, wr, rd} = 9'h180;
      {sup, mode, addr, wdata, used, cfgp} = '0;
      seed = $urandom(72);
      for (int i = 0; i < 6; i++)
      begin
         term       = 2'(i % 4);
         upull      = $urandom;
         sinv       = $urandom;
         rst_i      <= 1'b1;
         strap      <= i[0];
         strap_oe_n <= (i == 2);
         slow       <= i[1];
         mode       <= 3'($urandom);
         used       <= NP'($urandom);
         cfgp       <= NP'($urandom);
         sup        <= 3'h7 & ~(3'h1 << (i % 3));
         repeat (4) @(posedge core_clk_i);
         rst_i <= 1'b0;
         wr_reg(REG_CONTROL, {28'h0, term, 2'h0});
         wr_reg(REG_USERPULL, upull);
         wr_reg(REG_SRINV, sinv);
         wr_reg(4'h9, 32'hffff_ffff);
         rd_reg(REG_CONTROL, got);
         chk("control", {28'h0, term, 2'h0}, got);
         rd_reg(4'h9, got);
         chk("unmapped", 32'h0, got);
         repeat (20) @(posedge core_clk_i);
         #1 chk("one supply low", 32'h0, {mclr, init_n});
         @(posedge core_clk_i);
         sup <= 3'h7;
         for (int k = 0; k < 400 && global_write_enable !== 1'b1; k++)
            @(posedge core_clk_i);
         repeat (2) @(posedge core_clk_i);
         #1 chk("mode", mode, cmode);
         chk("oe_n", NP'(~used), oe_n);
         chk("pullup", exp_pull(1'b0), pup);
         chk("pulldown", exp_pull(1'b1), pdn);
         chk("init value", sinv[NP-1:0], rinit);
         chk("strap gpio", 32'h1, gpio);
         chk("write enable", 32'h1, global_write_enable);
         @(posedge core_clk_i);
         mode   <= ~mode;
         extest <= i[0];
         highz  <= !i[0];
         rd_reg(REG_STATUS, got);
         chk("status", {~mode, 3'h5}, got[5:0]);
         chk("scan pulldown", {NP{1'b1}}, pdn);
         extest <= 1'b0;
         highz  <= 1'b0;
         // Clock enable low freezes everything, even through a supply loss
         ce     <= 1'b0;
         sup[i % 3] <= 1'b0;
         repeat (6) @(posedge core_clk_i);
         #1 chk("frozen gwe", 32'h1, global_write_enable);
         @(posedge core_clk_i);
         ce <= 1'b1;
         repeat (6) @(posedge core_clk_i);
         #1 chk("por state", {3'h6, {NP{1'b1}}}, {global_set_reset, global_output_tristate, global_write_enable, oe_n});
         @(posedge core_clk_i);
      end
      end_sim();
   end
endmodule
